// >>> rtl/prb_pkg.sv
// constants shared by the pwm run, transfer and brake logic
`default_nettype none

package prb_pkg;

	localparam int unsigned CH_NUM  = 4;
	localparam int unsigned CNT_W   = 10;
	localparam int unsigned ADDR_W  = 12;

	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_RELOAD_LO  = 8'hD1;
	localparam logic [7:0] IDX_RELOAD_HI  = 8'hD2;
	localparam logic [7:0] IDX_CMP_LO0    = 8'hD3;
	localparam logic [7:0] IDX_CMP_HI     = 8'hD7;
	localparam logic [7:0] IDX_RUN_CTRL   = 8'hDA;
	localparam logic [7:0] IDX_BRAKE_CTRL = 8'hDB;
	localparam logic [7:0] IDX_STATUS     = 8'hDC;

	// pwm_run_control fields
	localparam int unsigned RUN_BIT  = 7;
	localparam int unsigned SHADOW_TRANSFER_REQUEST_BIT = 6;
	localparam logic [3:0][2:0] INV_BIT_POS = {3'h5, 3'h4, 3'h2, 3'h1};

	// brake_control fields
	localparam int unsigned HALT_SEL_BIT = 7;
	localparam int unsigned PIN_POL_BIT  = 6;
	localparam int unsigned PIN_EN_BIT   = 5;
	localparam int unsigned BRAKE_EN_BIT = 4;

	// compare high register holds two bits per channel
	localparam int unsigned CMP_HI_W = 2;

	localparam logic [9:0] CMP_ZERO     = 10'h000;
	localparam logic [9:0] CMP_ALL_ONES = 10'h3FF;
	localparam logic [9:0] CNT_STEP     = 10'h001;

	localparam logic [7:0] RUN_CTRL_RST   = 8'h00;
	localparam logic [7:0] BRAKE_CTRL_RST = 8'h00;
	localparam logic [9:0] SHADOW_RST     = 10'h000;
	localparam logic       OUT_RST        = 1'b1;

endpackage : prb_pkg

`default_nettype wire

// >>> rtl/prb_chan.sv
// one pwm channel: compare waveform, halt hold, inversion and brake forcing
`default_nettype none

module prb_chan
	import prb_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [9:0] count,
	input  wire logic [9:0] cmp,
	input  wire logic       underflow,
	input  wire logic       update,
	input  wire logic       invert,
	input  wire logic       brake,
	input  wire logic       level,
	output logic            pwm_out
);

	typedef struct packed {
		logic raw;
		logic out;
	} prb_chan_state_t;

	prb_chan_state_t s_reg;
	prb_chan_state_t s_next;

	always_comb begin
		s_next = s_reg;
		// braking freezes the waveform so it resumes unchanged
		if (update) begin
			if (underflow) begin
				s_next.raw = (cmp != CMP_ALL_ONES);
			end else if (count == cmp && cmp != CMP_ZERO) begin
				s_next.raw = 1'b0;
			end
		end
		s_next.out = brake ? level : (s_reg.raw ^ invert);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{raw: OUT_RST, out: OUT_RST};
		end else begin
			s_reg <= s_next;
		end
	end

	assign pwm_out = s_reg.out;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_compare_hit;
		update && !underflow && count == cmp && cmp != CMP_ZERO;
	endsequence

	a_compare_low: assert property (s_compare_hit |=> !s_reg.raw ##1 1'b1)
		else $error("raw level not low after compare");
	a_halt_hold: assert property (!update |=> $stable(s_reg.raw))
		else $error("waveform moved while held");
	a_cycle_start: assert property (update && underflow && cmp != CMP_ALL_ONES |=> s_reg.raw)
		else $error("output not high at cycle start");
	a_invert_out: assert property (!brake |=> pwm_out == ($past(s_reg.raw) ^ $past(invert)))
		else $error("output does not follow inversion");

endmodule : prb_chan

`default_nettype wire

// >>> rtl/prb_top.sv
// pwm run control, shadow transfer, inversion and brake with an apb register slave
//
// What this block does
// - run 0 halts counter at its preset; run 1 lets it count down.
// - halted with brake asserted, each output equals its brake level bit.
// - halted without brake, outputs hold their last compare result.
// - shadows stay apart until transfer is set, then copy at next underflow.
// - hardware clears transfer after the copy so software can poll it.
// - per-channel invert bit swaps high and low phases of the output.
// - while brake is asserted all outputs take their brake level bits.
// - brake enable 0 means brake never asserts.
// - enabled with halt select and pin enable both 0: brake always on.
// - enabled with halt select 1: brake exactly while run is 0.
// - pin mode: brake while pin level equals the pin polarity bit.
// - a pin-caused brake clears the run bit.
// - when brake ends each output returns to its level before brake.
// - clearing run without halt-select brake keeps the outputs at their levels just before.
// - period counter is a 10-bit down counter reloaded at underflow.
// - output high from underflow until compare matches, then low.
// - compare zero or above reload stays high; all ones stays low.
//
// Our own choice: the APB register port.
`default_nettype none

module prb_top
	import prb_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              brake_pin,
	output logic [CH_NUM-1:0]      pwm_out
);

	typedef struct packed {
		logic                        run;
		logic                        shadow_transfer_request;
		logic [CH_NUM-1:0]           inv;
		logic [7:0]                  brk;
		logic [CNT_W-1:0]            reload_sh;
		logic [CNT_W-1:0]            reload_act;
		logic [CNT_W-1:0]            count;
		logic [CH_NUM-1:0][CNT_W-1:0] cmp_sh;
		logic [CH_NUM-1:0][CNT_W-1:0] cmp_act;
		logic [31:0]                 prdata;
	} prb_top_state_t;

	prb_top_state_t s_reg;
	prb_top_state_t s_next;

	logic                         wr_acc;
	logic                         rd_setup;
	logic                         mapped;
	logic                         underflow;
	logic                         brake_act;
	logic                         pin_brake;
	logic [CH_NUM-1:0][CNT_W-1:0] cmp_eff;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {2'h0, idx, 2'h0};
	endfunction : reg_hit

	function automatic logic [7:0] run_ctrl_image(input prb_top_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[RUN_BIT] = s.run;
		v[SHADOW_TRANSFER_REQUEST_BIT] = s.shadow_transfer_request;
		for (int i = 0; i < CH_NUM; i++) begin
			v[INV_BIT_POS[i]] = s.inv[i];
		end
		return v;
	endfunction : run_ctrl_image

	////////////////////////////////////////////////////////////////////////
	// brake decode

	always_comb begin
		pin_brake = s_reg.brk[BRAKE_EN_BIT] && !s_reg.brk[HALT_SEL_BIT] && s_reg.brk[PIN_EN_BIT]
			&& (brake_pin == s_reg.brk[PIN_POL_BIT]);
		if (!s_reg.brk[BRAKE_EN_BIT]) begin
			brake_act = 1'b0;
		// illegal pair falls to halt select
		end else if (s_reg.brk[HALT_SEL_BIT]) begin
			brake_act = !s_reg.run;
		end else if (s_reg.brk[PIN_EN_BIT]) begin
			brake_act = pin_brake;
		end else begin
			brake_act = 1'b1;
		end
	end

	assign underflow = s_reg.run && s_reg.count == CMP_ZERO;
	assign wr_acc    = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;

	always_comb begin
		mapped = reg_hit(paddr, IDX_RELOAD_LO) || reg_hit(paddr, IDX_RELOAD_HI)
			|| reg_hit(paddr, IDX_CMP_HI) || reg_hit(paddr, IDX_RUN_CTRL)
			|| reg_hit(paddr, IDX_BRAKE_CTRL) || reg_hit(paddr, IDX_STATUS);
		for (int i = 0; i < CH_NUM; i++) begin
			if (reg_hit(paddr, 8'(IDX_CMP_LO0 + i))) begin
				mapped = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_next = s_reg;

		if (!s_reg.run) begin
			s_next.count = s_reg.reload_act;
		end else if (underflow) begin
			s_next.count = s_reg.shadow_transfer_request ? s_reg.reload_sh : s_reg.reload_act;
		end else begin
			s_next.count = s_reg.count - CNT_STEP;
		end

		if (underflow && s_reg.shadow_transfer_request) begin
			s_next.reload_act = s_reg.reload_sh;
			s_next.cmp_act = s_reg.cmp_sh;
			s_next.shadow_transfer_request = 1'b0;
		end

		// a software write in the same cycle wins, so a new request is never lost
		if (wr_acc) begin
			if (reg_hit(paddr, IDX_RUN_CTRL)) begin
				s_next.run = pwdata[RUN_BIT];
				s_next.shadow_transfer_request = pwdata[SHADOW_TRANSFER_REQUEST_BIT];
				for (int i = 0; i < CH_NUM; i++) begin
					s_next.inv[i] = pwdata[INV_BIT_POS[i]];
				end
			end
			if (reg_hit(paddr, IDX_BRAKE_CTRL)) begin
				s_next.brk = pwdata[7:0];
			end
			if (reg_hit(paddr, IDX_RELOAD_LO)) begin
				s_next.reload_sh[7:0] = pwdata[7:0];
			end
			if (reg_hit(paddr, IDX_RELOAD_HI)) begin
				s_next.reload_sh[9:8] = pwdata[1:0];
			end
			for (int i = 0; i < CH_NUM; i++) begin
				if (reg_hit(paddr, 8'(IDX_CMP_LO0 + i))) begin
					s_next.cmp_sh[i][7:0] = pwdata[7:0];
				end
				if (reg_hit(paddr, IDX_CMP_HI)) begin
					s_next.cmp_sh[i][9:8] = pwdata[CMP_HI_W*i +: CMP_HI_W];
				end
			end
		end

		// pin brake clears run
		// the pin stays the master while it is active, so it beats a software set
		if (pin_brake) begin
			s_next.run = 1'b0;
		end

		// read data is captured in the setup cycle so it leaves a flip-flop
		if (rd_setup) begin
			s_next.prdata = 32'h0000_0000;
			if (reg_hit(paddr, IDX_RUN_CTRL)) begin
				s_next.prdata[7:0] = run_ctrl_image(s_reg);
			end
			if (reg_hit(paddr, IDX_BRAKE_CTRL)) begin
				s_next.prdata[7:0] = s_reg.brk;
			end
			if (reg_hit(paddr, IDX_RELOAD_LO)) begin
				s_next.prdata[7:0] = s_reg.reload_sh[7:0];
			end
			if (reg_hit(paddr, IDX_RELOAD_HI)) begin
				s_next.prdata[1:0] = s_reg.reload_sh[9:8];
			end
			if (reg_hit(paddr, IDX_STATUS)) begin
				s_next.prdata[CH_NUM:0] = {brake_act, pwm_out};
			end
			for (int i = 0; i < CH_NUM; i++) begin
				if (reg_hit(paddr, 8'(IDX_CMP_LO0 + i))) begin
					s_next.prdata[7:0] = s_reg.cmp_sh[i][7:0];
				end
				if (reg_hit(paddr, IDX_CMP_HI)) begin
					s_next.prdata[CMP_HI_W*i +: CMP_HI_W] = s_reg.cmp_sh[i][9:8];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{
				run:        RUN_CTRL_RST[RUN_BIT],
				shadow_transfer_request:       RUN_CTRL_RST[SHADOW_TRANSFER_REQUEST_BIT],
				inv:        '0,
				brk:        BRAKE_CTRL_RST,
				reload_sh:  SHADOW_RST,
				reload_act: SHADOW_RST,
				count:      SHADOW_RST,
				cmp_sh:     '0,
				cmp_act:    '0,
				prdata:     32'h0000_0000
			};
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata  = s_reg.prdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	////////////////////////////////////////////////////////////////////////
	// channels

	for (genvar g = 0; g < CH_NUM; g++) begin : g_chan
		// the cycle that starts at a transfer already uses the new compare
		assign cmp_eff[g] = (underflow && s_reg.shadow_transfer_request) ? s_reg.cmp_sh[g] : s_reg.cmp_act[g];

		prb_chan u_chan (
			.pclk      (pclk),
			.presetn   (presetn),
			.count     (s_reg.count),
			.cmp       (cmp_eff[g]),
			.underflow (underflow),
			.update    (s_reg.run && !brake_act),
			.invert    (s_reg.inv[g]),
			.brake     (brake_act),
			.level     (s_reg.brk[g]),
			.pwm_out   (pwm_out[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_shadow_transfer_request_due;
		underflow && s_reg.shadow_transfer_request && !(wr_acc && reg_hit(paddr, IDX_RUN_CTRL));
	endsequence

	a_halt_preset: assert property (!s_reg.run |=> s_reg.count == $past(s_reg.reload_act))
		else $error("halted counter not at preset");
	a_count_down: assert property (s_reg.run && !underflow |=> s_reg.count == $past(s_reg.count) - CNT_STEP)
		else $error("counter did not step down");
	a_shadow_transfer_request_copy: assert property (s_shadow_transfer_request_due |=> s_reg.reload_act == $past(s_reg.reload_sh) && !s_reg.shadow_transfer_request)
		else $error("transfer did not copy and clear");
	a_shadow_transfer_request_wait: assert property (!underflow |=> $stable(s_reg.cmp_act) && $stable(s_reg.reload_act))
		else $error("active values changed off underflow");
	a_brake_levels: assert property (brake_act |=> pwm_out == $past(s_reg.brk[3:0]))
		else $error("outputs not at brake levels");
	a_brake_off: assert property (!s_reg.brk[BRAKE_EN_BIT] |-> !brake_act)
		else $error("brake asserted while disabled");
	a_brake_always: assert property (s_reg.brk[7:4] == 4'h1 |-> brake_act)
		else $error("always-on brake missing");
	a_halt_brake: assert property (s_reg.brk[BRAKE_EN_BIT] && s_reg.brk[HALT_SEL_BIT] |-> brake_act == !s_reg.run)
		else $error("halt brake does not follow run");
	a_pin_run_clear: assert property (pin_brake |=> !s_reg.run && $past(brake_act))
		else $error("pin brake left run set");
	a_ctrl_spare: assert property (rd_setup && reg_hit(paddr, IDX_RUN_CTRL) |=> prdata[3] == 1'b0 && prdata[0] == 1'b0)
		else $error("unused control bits read nonzero");

endmodule : prb_top

`default_nettype wire

// >>> bench/prb_stage_model.sv
// power stage model: counts on-time per channel and reports a trip on the brake pin
`default_nettype none

module prb_stage_model
	import prb_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic [CH_NUM-1:0] pwm_out,
	input  wire logic              clr,
	input  wire logic              trip,
	output logic                   brake_pin,
	output logic [3:0][7:0]        on_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	initial brake_pin = 1'b0;
	initial on_cnt = '0;

	// the fault latch is registered, so a trip reaches the pin one cycle late
	always @(posedge pclk) begin
		brake_pin <= trip;
		for (int i = 0; i < CH_NUM; i++) begin
			on_cnt[i] <= clr ? 8'h00 : on_cnt[i] + {7'h00, pwm_out[i]};
		end
	end
endmodule : prb_stage_model

`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the pwm run, transfer and brake block
`default_nettype none

module testbench
	import prb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              brake_pin;
	logic [CH_NUM-1:0] pwm_out;
	logic              clr = 1'b0;
	logic              trip = 1'b0;
	logic [3:0][7:0]   on_cnt;
	logic [31:0]       rdat;
	logic              err;
	int                failures = 0;
	int                compares = 0;

	always #12.5 pclk = ~pclk;

	prb_top DUT (
		.pclk      (pclk),
		.presetn   (presetn),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.brake_pin (brake_pin),
		.pwm_out   (pwm_out)
	);

	prb_stage_model stage (
		.pclk      (pclk),
		.pwm_out   (pwm_out),
		.clr       (clr),
		.trip      (trip),
		.brake_pin (brake_pin),
		.on_cnt    (on_cnt)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			check(32'h0, 32'h1, "pready timeout");
			wrap_up();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 8'h00);
		check(rdat, exp, what);
	endtask : rd

	// shadow copy is done once the hardware drops the transfer bit
	task automatic poll_shadow_transfer_request();
		for (int i = 0; i < 50; i++) begin
			apb(1'b0, IDX_RUN_CTRL, 8'h00);
			if (rdat[SHADOW_TRANSFER_REQUEST_BIT] === 1'b0) return;
		end
		check(rdat, 32'h0, "transfer never cleared");
		wrap_up();
	endtask : poll_shadow_transfer_request

	// 40 cycles is a whole number of periods, so phase does not matter
	task automatic window(input logic [31:0] exp);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		cyc(40);
		check(on_cnt, exp, "on-time per channel");
	endtask : window

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		check({28'h0, pwm_out}, 32'hF, "reset outputs");
		rd(IDX_RUN_CTRL, 32'h0, "run control reset");
		rd(IDX_BRAKE_CTRL, 32'h0, "brake control reset");
		wr(IDX_RUN_CTRL, 8'h3F);
		check({31'h0, err}, 32'h0, "mapped write error");
		rd(IDX_RUN_CTRL, 32'h36, "unused control bits");
		wr(IDX_RUN_CTRL, 8'h00);
		apb(1'b0, 8'h10, 8'h00);
		check({31'h0, err}, 32'h1, "unmapped error");
		check(rdat, 32'h0, "unmapped read data");
		$display("test regs done");
	endtask : t_regs

	task automatic t_wave();
		wr(IDX_RELOAD_LO, 8'h03);
		wr(IDX_RELOAD_HI, 8'h00);
		wr(IDX_CMP_LO0, 8'h02);
		wr(IDX_CMP_LO0 + 8'h01, 8'h03);
		// one above the reload value never matches
		wr(IDX_CMP_LO0 + 8'h02, 8'h04);
		wr(IDX_CMP_LO0 + 8'h03, 8'hFF);
		wr(IDX_CMP_HI, 8'hC0);
		// run without transfer keeps the old active values: all high
		wr(IDX_RUN_CTRL, 8'h80);
		window(32'h28282828);
		wr(IDX_RUN_CTRL, 8'hC4);
		poll_shadow_transfer_request();
		window(32'h00281E14);
		$display("test wave done");
	endtask : t_wave

	task automatic t_halt();
		for (int i = 0; i < 5; i++) begin
			wr(IDX_CMP_LO0 + i[7:0], 8'h00);
		end
		wr(IDX_RUN_CTRL, 8'hC0);
		poll_shadow_transfer_request();
		cyc(8);
		wr(IDX_RUN_CTRL, 8'h00);
		cyc(3);
		check({28'h0, pwm_out}, 32'hF, "outputs after halt");
		window(32'h28282828);
		$display("test halt done");
	endtask : t_halt

	task automatic t_brake_sw();
		wr(IDX_BRAKE_CTRL, 8'h95);
		cyc(3);
		check({28'h0, pwm_out}, 32'h5, "brake on halt");
		wr(IDX_RUN_CTRL, 8'h80);
		cyc(3);
		check({28'h0, pwm_out}, 32'hF, "brake released by run");
		wr(IDX_RUN_CTRL, 8'h00);
		wr(IDX_BRAKE_CTRL, 8'h1A);
		cyc(3);
		check({28'h0, pwm_out}, 32'hA, "brake always");
		rd(IDX_STATUS, 32'h1A, "status in brake");
		wr(IDX_BRAKE_CTRL, 8'h0A);
		cyc(3);
		check({28'h0, pwm_out}, 32'hF, "brake disabled");
		$display("test brake sw done");
	endtask : t_brake_sw

	task automatic t_pin();
		// pin mode, high active, levels C; halt select stays 0
		wr(IDX_BRAKE_CTRL, 8'h7C);
		wr(IDX_RUN_CTRL, 8'h80);
		cyc(3);
		check({28'h0, pwm_out}, 32'hF, "pin inactive");
		@(posedge pclk);
		trip <= 1'b1;
		cyc(4);
		check({28'h0, pwm_out}, 32'hC, "pin brake high");
		rd(IDX_RUN_CTRL, 32'h0, "run cleared by pin");
		@(posedge pclk);
		trip <= 1'b0;
		cyc(4);
		check({28'h0, pwm_out}, 32'hF, "pin released");
		// a one-cycle trip is too short to poll, the cleared run bit keeps it
		wr(IDX_RUN_CTRL, 8'h80);
		@(posedge pclk);
		trip <= 1'b1;
		@(posedge pclk);
		trip <= 1'b0;
		cyc(4);
		check({28'h0, pwm_out}, 32'hF, "after short trip");
		rd(IDX_RUN_CTRL, 32'h0, "short trip caught");
		// low active with the pin low
		wr(IDX_BRAKE_CTRL, 8'h33);
		cyc(3);
		check({28'h0, pwm_out}, 32'h3, "pin brake low");
		// leave pin brake: halt brake, brake pattern compares, then run and transfer
		wr(IDX_BRAKE_CTRL, 8'h93);
		wr(IDX_CMP_LO0 + 8'h02, 8'hFF);
		wr(IDX_CMP_LO0 + 8'h03, 8'hFF);
		wr(IDX_CMP_HI, 8'hF0);
		cyc(2);
		check({28'h0, pwm_out}, 32'h3, "software brake pattern");
		wr(IDX_RUN_CTRL, 8'hC0);
		poll_shadow_transfer_request();
		cyc(2);
		check({28'h0, pwm_out}, 32'h3, "run with brake pattern");
		rd(IDX_RUN_CTRL, 32'h80, "run kept after pin brake");
		$display("test pin done");
	endtask : t_pin

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		cyc(1);
		t_regs();
		t_wave();
		t_halt();
		t_brake_sw();
		t_pin();
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
